// *** pmc_pkg.sv ***
// Package for the power mode controller: register map, field layout, timing.
// Assumes an 8-bit special-function register port from the processor core.
package pmc_pkg;
	// Register offsets in special-function register space
	localparam logic [7:0] PMC_MODE_CTRL_ADDR = 8'h87;
	localparam logic [7:0] PMC_SLEEP_CTRL_ADDR = 8'hbe;
	// Power mode control register fields
	localparam int PMC_ENTRY_BIT = 0;
	localparam int PMC_RSVD_BIT = 1;
	localparam logic [7:0] PMC_MODE_CTRL_RST = 8'h00;
	// Sleep control register fields
	localparam int PMC_MODE_LSB = 0;
	localparam int PMC_MODE_MSB = 1;
	localparam int PMC_XSTB_BIT = 6;
	localparam int PMC_USB_BIT = 7;
	// Mode field encodings
	localparam logic [1:0] PMC_MODE_CPU_GATED = 2'h0;
	localparam logic [1:0] PMC_MODE_LIGHT = 2'h1;
	localparam logic [1:0] PMC_MODE_DEEP = 2'h2;
	localparam logic [1:0] PMC_MODE_OFF = 2'h3;
	// Sequence timing at 250 MHz
	localparam int PMC_CLK_MHZ = 250;
	localparam int PMC_FAST_SEQ_NS = 40;
	localparam int PMC_SLOW_SEQ_NS = 200;
	localparam int PMC_FAST_CYC = (PMC_FAST_SEQ_NS * PMC_CLK_MHZ + 999) / 1000;
	localparam int PMC_SLOW_CYC = (PMC_SLOW_SEQ_NS * PMC_CLK_MHZ + 999) / 1000;
	localparam int PMC_CNT_W = 8;
	// Controller states
	typedef enum logic [2:0] {
		PMC_ACTIVE,
		PMC_GATED,
		PMC_POWER_DOWN,
		PMC_ASLEEP,
		PMC_POWER_UP
	} pmc_state_t;
endpackage : pmc_pkg

// *** pmc_seq_timer.sv ***
// Down-counter timing the power-down and power-up sequences.
// Assumes the controller loads it once per sequence step.
`timescale 1ns/1ps
`default_nettype none
module pmc_seq_timer (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         clkEn,
	// Control
	input  wire logic                         load,
	input  wire logic [pmc_pkg::PMC_CNT_W-1:0] loadVal,
	// Status
	output logic                              done
);
	typedef struct packed {
		logic [pmc_pkg::PMC_CNT_W-1:0] cnt;
	} pmc_tmr_t;
	pmc_tmr_t st_ff;
	pmc_tmr_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (load) begin
			nxt_st.cnt = loadVal;
		end else if (st_ff.cnt != '0) begin
			nxt_st.cnt = st_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else if (clkEn) begin
			st_ff <= nxt_st;
		end
	end

	assign done = (st_ff.cnt == '0) && !load;
endmodule : pmc_seq_timer
`default_nettype wire

// *** pmc_power_mode_ctrl.sv ***
// Power mode controller: sequences active mode and four low-power states.
// Assumes a synchronous SFR port from the core and level wake requests.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Active keeps regulator on, a fast oscillator and one slow oscillator running.
// - CPU-gated state stops only the CPU clock; peripherals keep running.
// - Any enabled interrupt returns CPU-gated state to active, resuming in place.
// - Light sleep stops both fast oscillators; regulator and slow clock stay on.
// - Deep sleep also switches off the core regulator; RAM is kept.
// - Off state stops regulator and all oscillators; only reset, pins and power-on wake end it.
// - Pins hold direction and level on entry to any sleep state.
// - Light sleep uses a fast sequence; deep and off share a slower one.
// - Pins wake all sleeps; sleep timer wakes light and deep only; resume.
// - Reset in any low-power state restarts the program from its start.
// - USB state is discarded on entering deep sleep or off.
// - Writing one to entry strobe enters the state the mode field selects.
// - Pin, timer or power-on wake clears mode field and entry strobe.
// - Pin and sleep timer interrupts are blocked while mode is nonzero.
// - Hardware clears the mode field when a sleep state is actually entered.
// - On wake restart fast oscillators; RC clocks system until crystal stable.
// - Entry strobe reads zero and is cleared by any interrupt request.
// - Register bits except mode field and USB enable keep values across deep sleep and off entry.
// - Mode field: 00 gated, 01 light, 10 deep, 11 off; resets to 00.
// - Crystal-stable flag reads one only when crystal is powered and stable.
module pmc_power_mode_ctrl (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       clkEn,
	// SFR port
	input  wire logic       sfrWr,
	input  wire logic       sfrRd,
	input  wire logic [7:0] sfrAddr,
	input  wire logic [7:0] sfrWdata,
	output logic      [7:0] sfrRdata,
	// Wake and interrupt sources
	input  wire logic       pinIrq,
	input  wire logic       sleepTimerIrq,
	input  wire logic       anyIrq,
	input  wire logic       porWake,
	// Oscillator status and selection
	input  wire logic       crystalStableRaw,
	input  wire logic       sysclkSourceSelect,
	input  wire logic       slowClockSourceSelect,
	// Power and clock controls
	output logic            cpuClkGate,
	output logic            periphClkGate,
	output logic            coreRegOn,
	output logic            crystalOscEn,
	output logic            rcOscEn,
	output logic            slowXtalEn,
	output logic            slowRcEn,
	output logic            sysclkOnRc,
	output logic            pinHold,
	output logic            usbReset,
	output logic            wakeIrqPass,
	output logic            programRestart
);
	typedef struct packed {
		pmc_pkg::pmc_state_t state;
		logic [1:0]          mode;
		logic [1:0]          target;
		logic                usbEn;
		logic                xtalRan;
		logic                rcRan;
		logic [7:0]          rdata;
		logic                cpuGate;
		logic                perGate;
		logic                regOn;
		logic                xtalEn;
		logic                rcEn;
		logic                onRc;
		logic                hold;
		logic                usbRst;
		logic                irqPass;
		logic                restart;
		logic                timerLoad;
		logic [pmc_pkg::PMC_CNT_W-1:0] timerVal;
		logic                slowXtal;
		logic                slowRc;
	} pmc_ctrl_t;

	pmc_ctrl_t st_ff;
	pmc_ctrl_t nxt_st;
	logic      seqDone;

	// Wake source decode used in several states
	function automatic logic wakeHit(input logic [1:0] tgt, input logic pin, input logic tmr);
		wakeHit = pin || (tmr && (tgt != pmc_pkg::PMC_MODE_OFF));
	endfunction : wakeHit

	function automatic logic [pmc_pkg::PMC_CNT_W-1:0] seqLen(input logic [1:0] tgt);
		if (tgt == pmc_pkg::PMC_MODE_LIGHT) begin
			seqLen = pmc_pkg::PMC_CNT_W'(pmc_pkg::PMC_FAST_CYC);
		end else begin
			seqLen = pmc_pkg::PMC_CNT_W'(pmc_pkg::PMC_SLOW_CYC);
		end
	endfunction : seqLen

	pmc_seq_timer uSeqTimer (
		.clk     (clk),
		.rst     (rst),
		.clkEn   (clkEn),
		.load    (st_ff.timerLoad),
		.loadVal (st_ff.timerVal),
		.done    (seqDone)
	);

	logic wrCtrl;
	logic wrSleep;
	logic wake;
	assign wrCtrl = sfrWr && (sfrAddr == pmc_pkg::PMC_MODE_CTRL_ADDR);
	assign wrSleep = sfrWr && (sfrAddr == pmc_pkg::PMC_SLEEP_CTRL_ADDR);
	assign wake = wakeHit(st_ff.target, pinIrq, sleepTimerIrq) || porWake;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.timerLoad = 1'b0;
		nxt_st.restart = 1'b0;
		// Blocked while a sleep is armed so the strobe cannot race a wake
		nxt_st.irqPass = (st_ff.mode == pmc_pkg::PMC_MODE_CPU_GATED);
		if (wrSleep) begin
			nxt_st.mode = sfrWdata[pmc_pkg::PMC_MODE_MSB:pmc_pkg::PMC_MODE_LSB];
			nxt_st.usbEn = sfrWdata[pmc_pkg::PMC_USB_BIT];
		end
		case (st_ff.state)
			pmc_pkg::PMC_ACTIVE: begin
				// Strobe is write-one-only; the reserved bit has no effect here
				if (wrCtrl && sfrWdata[pmc_pkg::PMC_ENTRY_BIT] && !anyIrq) begin
					nxt_st.target = nxt_st.mode;
					nxt_st.xtalRan = st_ff.xtalEn;
					nxt_st.rcRan = st_ff.rcEn;
					if (nxt_st.mode == pmc_pkg::PMC_MODE_CPU_GATED) begin
						nxt_st.cpuGate = 1'b1;
						nxt_st.state = pmc_pkg::PMC_GATED;
					end else begin
						nxt_st.hold = 1'b1;
						nxt_st.timerLoad = 1'b1;
						nxt_st.timerVal = seqLen(nxt_st.mode);
						nxt_st.state = pmc_pkg::PMC_POWER_DOWN;
					end
				end
			end
			pmc_pkg::PMC_GATED: begin
				if (anyIrq || porWake) begin
					nxt_st.cpuGate = 1'b0;
					nxt_st.state = pmc_pkg::PMC_ACTIVE;
				end
			end
			pmc_pkg::PMC_POWER_DOWN: begin
				if (wake || anyIrq) begin
					// Abort keeps the event pending at the source
					nxt_st.hold = 1'b0;
					nxt_st.mode = pmc_pkg::PMC_MODE_CPU_GATED;
					nxt_st.state = pmc_pkg::PMC_ACTIVE;
				end else if (seqDone) begin
					nxt_st.mode = pmc_pkg::PMC_MODE_CPU_GATED;
					nxt_st.cpuGate = 1'b1;
					nxt_st.perGate = 1'b1;
					nxt_st.xtalEn = 1'b0;
					nxt_st.rcEn = 1'b0;
					nxt_st.onRc = 1'b0;
					nxt_st.regOn = (st_ff.target == pmc_pkg::PMC_MODE_LIGHT);
					if (st_ff.target != pmc_pkg::PMC_MODE_LIGHT) begin
						nxt_st.usbRst = 1'b1;
						nxt_st.usbEn = 1'b0;
					end
					nxt_st.state = pmc_pkg::PMC_ASLEEP;
				end
			end
			pmc_pkg::PMC_ASLEEP: begin
				nxt_st.irqPass = 1'b1;
				if (wake) begin
					nxt_st.mode = pmc_pkg::PMC_MODE_CPU_GATED;
					nxt_st.regOn = 1'b1;
					nxt_st.xtalEn = st_ff.xtalRan;
					nxt_st.rcEn = st_ff.rcRan || !sysclkSourceSelect;
					nxt_st.onRc = !sysclkSourceSelect;
					nxt_st.timerLoad = 1'b1;
					nxt_st.timerVal = seqLen(st_ff.target);
					nxt_st.state = pmc_pkg::PMC_POWER_UP;
				end
			end
			pmc_pkg::PMC_POWER_UP: begin
				if (seqDone) begin
					nxt_st.cpuGate = 1'b0;
					nxt_st.perGate = 1'b0;
					nxt_st.hold = 1'b0;
					nxt_st.usbRst = 1'b0;
					nxt_st.state = pmc_pkg::PMC_ACTIVE;
				end
			end
			default: begin
				nxt_st.state = pmc_pkg::PMC_ACTIVE;
			end
		endcase
		// Crystal is powered in active mode whenever it is the selected system clock
		if (st_ff.state == pmc_pkg::PMC_ACTIVE && !sysclkSourceSelect) begin
			nxt_st.xtalEn = 1'b1;
		end
		// Crystal takes over once stable; RC stays on if it ran before entry
		if (st_ff.onRc && crystalStableRaw && st_ff.state == pmc_pkg::PMC_ACTIVE) begin
			nxt_st.onRc = 1'b0;
			nxt_st.rcEn = st_ff.rcRan;
		end
		// Slow clock follows its select; only the off state stops it
		nxt_st.slowXtal = !slowClockSourceSelect;
		nxt_st.slowRc = slowClockSourceSelect;
		if (nxt_st.state == pmc_pkg::PMC_ASLEEP && nxt_st.target == pmc_pkg::PMC_MODE_OFF) begin
			nxt_st.slowXtal = 1'b0;
			nxt_st.slowRc = 1'b0;
		end
		// Register reads; the strobe and reserved bits always read zero
		nxt_st.rdata = 8'h00;
		if (sfrRd && sfrAddr == pmc_pkg::PMC_SLEEP_CTRL_ADDR) begin
			nxt_st.rdata[pmc_pkg::PMC_MODE_MSB:pmc_pkg::PMC_MODE_LSB] = st_ff.mode;
			nxt_st.rdata[pmc_pkg::PMC_XSTB_BIT] = crystalStableRaw && st_ff.xtalEn;
			nxt_st.rdata[pmc_pkg::PMC_USB_BIT] = st_ff.usbEn;
		end
	end

	// A reset is the only path that restarts the program
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{state: pmc_pkg::PMC_ACTIVE, mode: pmc_pkg::PMC_MODE_CPU_GATED,
				target: pmc_pkg::PMC_MODE_CPU_GATED, usbEn: 1'b0, xtalRan: 1'b0,
				rcRan: 1'b1, rdata: pmc_pkg::PMC_MODE_CTRL_RST, cpuGate: 1'b0,
				perGate: 1'b0, regOn: 1'b1, xtalEn: 1'b0, rcEn: 1'b1, onRc: 1'b0,
				hold: 1'b0, usbRst: 1'b0, irqPass: 1'b1, restart: 1'b1,
				timerLoad: 1'b0, timerVal: '0, slowXtal: 1'b0,
				slowRc: 1'b1};
		end else if (clkEn) begin
			st_ff <= nxt_st;
		end
	end

	assign sfrRdata = st_ff.rdata;
	assign cpuClkGate = st_ff.cpuGate;
	assign periphClkGate = st_ff.perGate;
	assign coreRegOn = st_ff.regOn;
	assign crystalOscEn = st_ff.xtalEn;
	assign rcOscEn = st_ff.rcEn;
	assign slowXtalEn = st_ff.slowXtal;
	assign slowRcEn = st_ff.slowRc;
	assign sysclkOnRc = st_ff.onRc;
	assign pinHold = st_ff.hold;
	assign usbReset = st_ff.usbRst;
	assign wakeIrqPass = st_ff.irqPass;
	assign programRestart = st_ff.restart;

	// Checks
	AST_GATE_WAKE: assert property (@(posedge clk) disable iff (rst)
		clkEn && st_ff.state == pmc_pkg::PMC_GATED && anyIrq |=> !cpuClkGate)
		else $error("gated state did not wake on interrupt");
	AST_BLOCK: assert property (@(posedge clk) disable iff (rst)
		clkEn && st_ff.mode != pmc_pkg::PMC_MODE_CPU_GATED
		&& st_ff.state != pmc_pkg::PMC_ASLEEP |=> !wakeIrqPass)
		else $error("wake interrupts passed while mode armed");
	AST_MODE_CLR: assert property (@(posedge clk) disable iff (rst)
		st_ff.state == pmc_pkg::PMC_ASLEEP |-> st_ff.mode == pmc_pkg::PMC_MODE_CPU_GATED)
		else $error("mode field not cleared asleep");
	AST_HOLD: assert property (@(posedge clk) disable iff (rst)
		st_ff.state == pmc_pkg::PMC_ASLEEP |-> pinHold)
		else $error("pins not held asleep");
	AST_LIGHT_REG: assert property (@(posedge clk) disable iff (rst)
		st_ff.state == pmc_pkg::PMC_ASLEEP && st_ff.target == pmc_pkg::PMC_MODE_LIGHT
		|-> coreRegOn && !crystalOscEn && !rcOscEn)
		else $error("light sleep power state wrong");
	AST_DEEP_REG: assert property (@(posedge clk) disable iff (rst)
		st_ff.state == pmc_pkg::PMC_ASLEEP && st_ff.target != pmc_pkg::PMC_MODE_LIGHT
		|-> !coreRegOn && usbReset)
		else $error("deep sleep power state wrong");
	AST_OFF_SLOW: assert property (@(posedge clk) disable iff (rst)
		st_ff.state == pmc_pkg::PMC_ASLEEP && st_ff.target == pmc_pkg::PMC_MODE_OFF
		|-> !slowXtalEn && !slowRcEn)
		else $error("slow clock running in off state");
	AST_OFF_TMR: assert property (@(posedge clk) disable iff (rst)
		clkEn && st_ff.state == pmc_pkg::PMC_ASLEEP && st_ff.target == pmc_pkg::PMC_MODE_OFF
		&& sleepTimerIrq && !pinIrq && !porWake |=> st_ff.state == pmc_pkg::PMC_ASLEEP)
		else $error("sleep timer woke the off state");
	AST_ABORT: assert property (@(posedge clk) disable iff (rst)
		clkEn && st_ff.state == pmc_pkg::PMC_POWER_DOWN && pinIrq
		|=> st_ff.state == pmc_pkg::PMC_ACTIVE && !pinHold)
		else $error("power-down not aborted by wake");
	AST_ACTIVE_CLK: assert property (@(posedge clk) disable iff (rst)
		st_ff.state == pmc_pkg::PMC_ACTIVE |-> coreRegOn && (crystalOscEn || rcOscEn))
		else $error("active without fast oscillator");
	AST_STB_READ: assert property (@(posedge clk) disable iff (rst)
		clkEn && sfrRd && sfrAddr == pmc_pkg::PMC_MODE_CTRL_ADDR |=> sfrRdata == 8'h00)
		else $error("entry strobe read nonzero");
	COV_GATED: cover property (@(posedge clk) st_ff.state == pmc_pkg::PMC_GATED);
	COV_LIGHT: cover property (@(posedge clk) st_ff.state == pmc_pkg::PMC_ASLEEP
		&& st_ff.target == pmc_pkg::PMC_MODE_LIGHT);
	COV_OFF: cover property (@(posedge clk) st_ff.state == pmc_pkg::PMC_ASLEEP
		&& st_ff.target == pmc_pkg::PMC_MODE_OFF);
	COV_ABORT: cover property (@(posedge clk) st_ff.state == pmc_pkg::PMC_POWER_DOWN && pinIrq);
endmodule : pmc_power_mode_ctrl
`default_nettype wire

// *** pmc_wake_model.sv ***
// Wake-source and crystal model on the far side of the power mode controller.
// Assumes the bench raises the request lines just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pmc_wake_model #(
	parameter int STB_CYC = 24
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Requests from the bench
	input  wire logic pinReq,
	input  wire logic timerReq,
	input  wire logic otherReq,
	input  wire logic crystalOscEn,
	// Towards the controller
	output logic      pinIrq,
	output logic      sleepTimerIrq,
	output logic      anyIrq,
	output logic      crystalStableRaw
);
	int stbCnt;

	assign pinIrq        = pinReq;
	assign sleepTimerIrq = timerReq;
	// Wake sources are enabled interrupts as well
	assign anyIrq        = pinReq | timerReq | otherReq;

	// Stable only after a startup time with the crystal powered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stbCnt <= 0;
		end else if (crystalOscEn !== 1'b1) begin
			stbCnt <= 0;
		end else if (stbCnt < STB_CYC) begin
			stbCnt <= stbCnt + 1;
		end
	end
	assign crystalStableRaw = (crystalOscEn === 1'b1) && (stbCnt == STB_CYC);
endmodule : pmc_wake_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the power mode controller.
// Assumes the wake model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] A_CTRL = pmc_pkg::PMC_MODE_CTRL_ADDR;
	localparam logic [7:0] A_SLP  = pmc_pkg::PMC_SLEEP_CTRL_ADDR;
	localparam int         LIMIT  = 20000;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       sfrWr = 1'b0;
	logic       sfrRd = 1'b0;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata;
	logic       pinReq, timerReq, otherReq, slowSel;
	logic       pinIrq, sleepTimerIrq, anyIrq, crystalStableRaw;
	logic       cpuClkGate, periphClkGate, coreRegOn, crystalOscEn, rcOscEn, slowXtalEn;
	logic       slowRcEn, sysclkOnRc, pinHold, usbReset, wakeIrqPass, programRestart;
	logic       clkEn = 1'b1;
	logic       porWake = 1'b0;
	logic       sysSel = 1'b0;
	int         err_total = 0;
	int         tests_run = 0;
	int         cycles = 0;
	int         took[4];
	string      qName[$];
	logic [7:0] qVal[$];

	always #2 clk = ~clk;

	pmc_wake_model i_wake (.clk(clk), .rst(rst), .pinReq(pinReq), .timerReq(timerReq),
		.otherReq(otherReq), .crystalOscEn(crystalOscEn), .pinIrq(pinIrq),
		.sleepTimerIrq(sleepTimerIrq), .anyIrq(anyIrq), .crystalStableRaw(crystalStableRaw));
	pmc_power_mode_ctrl i_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .sfrWr(sfrWr),
		.sfrRd(sfrRd), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
		.pinIrq(pinIrq), .sleepTimerIrq(sleepTimerIrq), .anyIrq(anyIrq), .porWake(porWake),
		.crystalStableRaw(crystalStableRaw), .sysclkSourceSelect(sysSel),
		.slowClockSourceSelect(slowSel), .cpuClkGate(cpuClkGate),
		.periphClkGate(periphClkGate), .coreRegOn(coreRegOn), .crystalOscEn(crystalOscEn),
		.rcOscEn(rcOscEn), .slowXtalEn(slowXtalEn), .slowRcEn(slowRcEn),
		.sysclkOnRc(sysclkOnRc), .pinHold(pinHold), .usbReset(usbReset),
		.wakeIrqPass(wakeIrqPass), .programRestart(programRestart));

	task automatic wrap_up();
		$display("Checks run %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	// One strobe pulse; an idle edge always precedes it, so no signal is set twice at once
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
		tick(1);
		sfrWr = wr;
		sfrRd = !wr;
		sfrAddr = a;
		sfrWdata = d;
		tick(1);
		sfrWr = 1'b0;
		sfrRd = 1'b0;
	endtask : sfr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		qName.push_back(nm);
		qVal.push_back(e);
		sfr(1'b0, a, 8'h00);
	endtask : rd

	// Bounded wait; sampling after the edge so the design's updates have landed
	task automatic waitLvl(ref logic s, input logic v, output int n);
		for (n = 0; n < 400 && s !== v; n++) begin
			tick(1);
		end
		if (s !== v) begin
			err_total++;
			$display("CHECK FAILED waitLvl expected %h seen %h", v, s);
		end
	endtask : waitLvl

	task automatic sleep_in(input logic [1:0] md, output int n);
		int k;
		waitLvl(crystalStableRaw, crystalOscEn, k);
		sfr(1'b1, A_SLP, {6'h00, md});
		tick(3);
		chk("wakeIrqPass", 8'h00, wakeIrqPass);
		sfr(1'b1, A_CTRL, 8'h01);
		tick(1);
		chk("pinHold", 8'h01, pinHold);
		waitLvl(periphClkGate, 1'b1, n);
		chk("cpuClkGate", 8'h01, cpuClkGate);
		chk("fastOsc", 8'h00, crystalOscEn | rcOscEn);
		chk("coreRegOn", md == pmc_pkg::PMC_MODE_LIGHT, coreRegOn);
		chk("slowOn", md != pmc_pkg::PMC_MODE_OFF, slowXtalEn | slowRcEn);
		if (md != pmc_pkg::PMC_MODE_LIGHT) begin
			chk("usbReset", 8'h01, usbReset);
		end
		tick(1);
		chk("wakeIrqPass", 8'h01, wakeIrqPass);
		rd(A_SLP, 8'h00, "modeAsleep");
	endtask : sleep_in

	// Results of reads are compared as they appear, oldest note first
	always @(posedge clk) begin
		if (sfrRd === 1'b1) begin
			#1;
			chk(qName.pop_front(), qVal.pop_front(), sfrRdata);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			wrap_up();
		end
	end

	initial begin
		int n;
		logic [1:0] md;
		sfrAddr = 8'h00;
		sfrWdata = 8'h00;
		pinReq = 1'b0;
		timerReq = 1'b0;
		otherReq = 1'b0;
		slowSel = 1'b1;
		n = $urandom(32'ha4698467);
		tick(8);
		rst = 1'b0;
		tick(1);
		chk("programRestart", 8'h00, programRestart);
		rd(A_SLP, 8'h00, "sleepCtrl");
		rd(A_CTRL, pmc_pkg::PMC_MODE_CTRL_RST, "modeCtrl");
		rd(8'h80, 8'h00, "unmapped");
		sfr(1'b1, A_CTRL, 8'h01);
		tick(1);
		chk("cpuClkGate", 8'h01, cpuClkGate);
		chk("periphClkGate", 8'h00, periphClkGate);
		rd(A_CTRL, 8'h00, "strobeRead");
		otherReq = 1'b1;
		tick(1);
		chk("cpuClkGate", 8'h00, cpuClkGate);
		otherReq = 1'b0;
		for (int m = 1; m < 4; m++) begin
			md = 2'(m);
			slowSel = 1'($urandom);
			tick(2);
			chk("slowPick", slowSel, slowRcEn);
			chk("slowOne", 8'h01, slowXtalEn ^ slowRcEn);
			chk("fastOn", 8'h01, crystalOscEn | rcOscEn);
			sleep_in(md, took[m]);
			if (md == pmc_pkg::PMC_MODE_OFF) begin
				timerReq = 1'b1;
				tick(8);
				chk("timerInOff", 8'h01, periphClkGate);
				timerReq = 1'b0;
				clkEn = 1'b0;
				pinReq = 1'b1;
				tick(4);
				chk("frozenOff", 8'h01, periphClkGate);
				clkEn = 1'b1;
			end else begin
				pinReq = 1'($urandom);
				timerReq = !pinReq;
			end
			waitLvl(periphClkGate, 1'b0, n);
			waitLvl(pinHold, 1'b0, n);
			pinReq = 1'b0;
			timerReq = 1'b0;
			chk("cpuClkGate", 8'h00, cpuClkGate);
			chk("coreRegOn", 8'h01, coreRegOn);
			chk("noRestart", 8'h00, programRestart);
			if (crystalStableRaw !== 1'b1) begin
				chk("sysclkOnRc", 8'h01, sysclkOnRc);
			end
			waitLvl(crystalStableRaw, 1'b1, n);
			tick(2);
			chk("sysclkOnRc", 8'h00, sysclkOnRc);
			rd(A_SLP, {1'b0, crystalStableRaw, 6'h00}, "sleepCtrl");
		end
		chk("lightFaster", 8'h01, took[1] < took[2]);
		chk("deepLikeOff", 8'h01, took[2] == took[3]);
		sfr(1'b1, A_SLP, {6'h00, pmc_pkg::PMC_MODE_DEEP});
		tick(3);
		sfr(1'b1, A_CTRL, 8'h01);
		tick(4);
		pinReq = 1'b1;
		waitLvl(pinHold, 1'b0, n);
		pinReq = 1'b0;
		chk("abortRegOn", 8'h01, coreRegOn);
		chk("abortGates", 8'h00, periphClkGate | cpuClkGate);
		sfr(1'b1, A_SLP, 8'h00);
		sysSel = 1'b1;
		sleep_in(pmc_pkg::PMC_MODE_LIGHT, n);
		porWake = 1'b1;
		waitLvl(pinHold, 1'b0, n);
		porWake = 1'b0;
		chk("porWakeOnRc", 8'h00, sysclkOnRc);
		rd(A_SLP, {1'b0, crystalStableRaw, 6'h00}, "porWakeMode");
		sysSel = 1'b0;
		sleep_in(pmc_pkg::PMC_MODE_DEEP, n);
		rst = 1'b1;
		tick(1);
		chk("programRestart", 8'h01, programRestart);
		rst = 1'b0;
		tick(2);
		chk("programRestart", 8'h00, programRestart);
		chk("periphClkGate", 8'h00, periphClkGate);
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
